// File: pkg/asr_pkg.sv
// Overview of operation
// [R1] Incoming line data is oversampled at sixteen ticks per bit before the character shifter.
// [R2] The character shifter takes one bit per bit time from the recovery stage fed by the pin.
// [R3] The bit rate comes from a high/low divisor pair plus high-speed and wide-divider selects.
// [R4] With both selects set, software must load a divisor above one.
// [R5] Reception runs only with the clocked-mode select clear and the port enable set.
// [R6] The ninth-bit enable makes each character nine data bits long.
// [R7] Characters are accepted only while continuous receive enable is set.
// [R8] A finished character sets the receive flag and raises an interrupt when enabled.
// [R9] The status register shows the ninth bit and the error flags of the held character.
// [R10] Reading the data register returns the low eight bits of the character.
// [R11] Clearing continuous receive enable clears the receive errors.
// [R12] Software must also set global and peripheral enables in bits 7 and 6 of irq control.
// [R13] Address detect is chosen by its enable with nine-bit mode; a bit selects priority.
// [R14] With address detect on, characters whose ninth bit is clear are dropped silently.
// [R15] A stop bit sampled low marks a framing error in the status register.
// [R16] A character ending while data is still unread marks overrun and halts reception.
package asr_pkg;
    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam logic [11:0] ASR_CTRL_ADDR   = 12'h000;
    localparam logic [11:0] ASR_DIVL_ADDR   = 12'h004;
    localparam logic [11:0] ASR_DIVH_ADDR   = 12'h008;
    localparam logic [11:0] ASR_STAT_ADDR   = 12'h00C;
    localparam logic [11:0] ASR_DATA_ADDR   = 12'h010;
    localparam logic [11:0] ASR_IRQS_ADDR   = 12'h014;
    localparam logic [11:0] ASR_IRQM_ADDR   = 12'h018;
    localparam logic [11:0] ASR_INTC_ADDR   = 12'h01C;
    // Control field positions
    localparam int ASR_C_SERIAL_PORT_ENABLE  = 0;
    localparam int ASR_C_SYNC  = 1;
    localparam int ASR_C_CONTINUOUS_RECEIVE_ENABLE  = 2;
    localparam int ASR_C_NINE  = 3;
    localparam int ASR_C_ADDR  = 4;
    localparam int ASR_C_HSEL  = 5;
    localparam int ASR_C_WSEL  = 6;
    localparam int ASR_C_RIE   = 7;
    localparam int ASR_C_PRIO  = 8;
    localparam int ASR_CTRL_W  = 9;
    // Status / irq positions
    localparam int ASR_S_NINTH = 0;
    localparam int ASR_S_FERR  = 1;
    localparam int ASR_S_OERR  = 2;
    localparam int ASR_S_FULL  = 3;
    localparam int ASR_I_RX    = 0;
    localparam int ASR_I_FERR  = 1;
    localparam int ASR_I_OERR  = 2;
    localparam int ASR_IRQ_W   = 3;
    localparam int ASR_INTC_GIE  = 7;
    localparam int ASR_INTC_PERIPHERAL_IRQ_ENABLE = 6;
    // Timing
    localparam logic [3:0]  ASR_OVS_LAST = 4'hF;
    localparam logic [3:0]  ASR_OVS_MID  = 4'h7;
    localparam logic [3:0]  ASR_BITS8    = 4'h8;
    localparam logic [3:0]  ASR_BITS9    = 4'h9;
    localparam logic [15:0] ASR_DIV_RST  = 16'h0000;
    localparam logic [31:0] ASR_ZERO     = 32'h0000_0000;

    // Receiver states
    typedef enum logic [3:0] {
        ASR_IDLE  = 4'b0001,
        ASR_START = 4'b0010,
        ASR_DATA  = 4'b0100,
        ASR_STOP  = 4'b1000
    } asr_state_t;

    // Held character with its flags
    typedef struct packed {
        logic       ninth;
        logic       ferr;
        logic [7:0] data;
    } asr_char_t;
endpackage

// File: hdl/asr_top.sv
`timescale 1ns/1ps
`default_nettype none
module asr_top (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Serial line
    input  wire logic        receive_pin,
    // Interrupt
    output logic             irq,
    output logic             receive_irq_priority
);
    import asr_pkg::*;

    // ****************************************
    // Registers
    // ****************************************
    logic [ASR_CTRL_W-1:0] ctrl_ff;
    logic [7:0]            div_lo_ff;
    logic [7:0]            div_hi_ff;
    logic [7:0]            intc_ff;
    logic [ASR_IRQ_W-1:0]  irqs_ff;
    logic [ASR_IRQ_W-1:0]  irqm_ff;
    asr_char_t             hold_ff;
    logic                  full_ff;
    logic                  oerr_ff;
    logic                  rx_s1_ff;
    logic                  rx_s2_ff;
    logic [18:0]           bcnt_ff;
    logic                  tick_ff;
    logic [3:0]            ovs_ff;
    logic [3:0]            nbit_ff;
    logic [8:0]            shift_ff;
    asr_state_t            state_ff;
    logic                  done_ff;
    logic                  done_ferr_ff;

    logic        wr_en;
    logic        rd_en;
    logic        port_on;
    logic        rx_on;
    logic [18:0] div_tick;
    logic [15:0] divisor;
    logic [3:0]  nbits;
    logic        accept;

    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && penable && !pwrite;
    assign port_on = ctrl_ff[ASR_C_SERIAL_PORT_ENABLE] && !ctrl_ff[ASR_C_SYNC];    // [R5]
    assign rx_on   = port_on && ctrl_ff[ASR_C_CONTINUOUS_RECEIVE_ENABLE] && !oerr_ff;     // [R7] [R16]
    assign divisor = {div_hi_ff, div_lo_ff};
    assign nbits   = ctrl_ff[ASR_C_NINE] ? ASR_BITS9 : ASR_BITS8;    // [R6]
    // Address detect drops characters whose ninth bit is low
    assign accept  = !(ctrl_ff[ASR_C_ADDR] && ctrl_ff[ASR_C_NINE]
                       && !shift_ff[8]);                              // [R13] [R14]

    // ****************************************
    // Baud tick at sixteen per bit
    // ****************************************
    // Tick period in clocks: wide+fast = n+1, else scaled so the x16 sampler
    // keeps the classic bit rates (fast: n+1, slow: 4x that, 4(n+1))
    always_comb begin
        // Nineteen bits: a full divisor plus one, times four, must not wrap
        div_tick = {3'h0, divisor} + 19'h00001;
        if (!ctrl_ff[ASR_C_WSEL]) begin
            div_tick = {11'h000, div_lo_ff} + 19'h00001;
        end
        if (!ctrl_ff[ASR_C_HSEL]) begin
            div_tick = {div_tick[16:0], 2'h0};
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bcnt_ff <= 19'h00000;
            tick_ff <= 1'b0;
        end else if (!port_on || bcnt_ff + 19'h00001 >= div_tick) begin
            bcnt_ff <= 19'h00000;
            tick_ff <= port_on;                                      // [R3]
        end else begin
            bcnt_ff <= bcnt_ff + 19'h00001;
            tick_ff <= 1'b0;
        end
    end

    // Two-flop synchroniser on the line
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_s1_ff <= 1'b1;
            rx_s2_ff <= 1'b1;
        end else begin
            rx_s1_ff <= receive_pin;
            rx_s2_ff <= rx_s1_ff;
        end
    end

    // ****************************************
    // Recovery sampler and shifter
    // ****************************************
    // Mid-bit sampling; a start glitch shorter than half a bit is rejected
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff     <= ASR_IDLE;
            ovs_ff       <= 4'h0;
            nbit_ff      <= 4'h0;
            shift_ff     <= 9'h000;
            done_ff      <= 1'b0;
            done_ferr_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            if (!rx_on) begin
                state_ff <= ASR_IDLE;
            end else if (tick_ff) begin                              // [R1]
                ovs_ff <= ovs_ff + 4'h1;
                case (state_ff)
                    ASR_IDLE: begin
                        ovs_ff <= 4'h0;
                        if (!rx_s2_ff) begin
                            state_ff <= ASR_START;
                        end
                    end
                    ASR_START: begin
                        if (ovs_ff == ASR_OVS_MID) begin
                            ovs_ff   <= 4'h0;
                            nbit_ff  <= 4'h0;
                            state_ff <= rx_s2_ff ? ASR_IDLE : ASR_DATA;
                        end
                    end
                    ASR_DATA: begin
                        if (ovs_ff == ASR_OVS_LAST) begin            // [R2]
                            shift_ff <= ctrl_ff[ASR_C_NINE]
                                      ? {rx_s2_ff, shift_ff[8:1]}
                                      : {1'b0, rx_s2_ff, shift_ff[7:1]}; // [R6]
                            nbit_ff  <= nbit_ff + 4'h1;
                            if (nbit_ff + 4'h1 == nbits) begin
                                state_ff <= ASR_STOP;
                            end
                        end
                    end
                    ASR_STOP: begin
                        if (ovs_ff == ASR_OVS_LAST) begin
                            done_ff      <= 1'b1;
                            done_ferr_ff <= !rx_s2_ff;                // [R15]
                            state_ff     <= ASR_IDLE;
                        end
                    end
                    default: begin
                        state_ff <= ASR_IDLE;
                    end
                endcase
            end
        end
    end

    // ****************************************
    // Holding register and errors
    // ****************************************
    // Done is registered once after the stop sample, so address detect sees final shift
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hold_ff <= '0;
            full_ff <= 1'b0;
            oerr_ff <= 1'b0;
        end else begin
            if (rd_en && paddr == ASR_DATA_ADDR) begin
                full_ff <= 1'b0;                                     // [R10]
            end
            if (done_ff && accept) begin
                if (full_ff) begin
                    oerr_ff <= 1'b1;                                 // [R16]
                end else begin
                    hold_ff.data  <= shift_ff[7:0];
                    hold_ff.ninth <= shift_ff[8];                    // [R9]
                    hold_ff.ferr  <= done_ferr_ff;                   // [R15]
                    full_ff       <= 1'b1;                           // [R8]
                end
            end
            if (!ctrl_ff[ASR_C_CONTINUOUS_RECEIVE_ENABLE]) begin
                oerr_ff      <= 1'b0;                                // [R11]
                hold_ff.ferr <= 1'b0;
            end
        end
    end

    // ****************************************
    // Software registers
    // ****************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_ff   <= '0;
            div_lo_ff <= ASR_DIV_RST[7:0];
            div_hi_ff <= ASR_DIV_RST[15:8];
            intc_ff   <= 8'h00;
            irqm_ff   <= '0;
        end else if (wr_en) begin
            case (paddr)
                ASR_CTRL_ADDR: ctrl_ff   <= pwdata[ASR_CTRL_W-1:0];  // [R3] [R13]
                ASR_DIVL_ADDR: div_lo_ff <= pwdata[7:0];
                ASR_DIVH_ADDR: div_hi_ff <= pwdata[7:0];
                ASR_IRQM_ADDR: irqm_ff   <= pwdata[ASR_IRQ_W-1:0];
                ASR_INTC_ADDR: intc_ff   <= pwdata[7:0];
                default: begin
                end
            endcase
        end
    end

    // Sticky events; a new event wins over a same-cycle clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irqs_ff <= '0;
        end else begin
            if (wr_en && paddr == ASR_IRQS_ADDR) begin
                irqs_ff <= irqs_ff & ~pwdata[ASR_IRQ_W-1:0];
            end
            // Only bits that really fire override a clear of the same cycle
            if (done_ff && accept) begin
                irqs_ff[ASR_I_RX] <= 1'b1;                           // [R8]
                if (done_ferr_ff) begin
                    irqs_ff[ASR_I_FERR] <= 1'b1;                     // [R15]
                end
                if (full_ff) begin
                    irqs_ff[ASR_I_OERR] <= 1'b1;                     // [R16]
                end
            end
        end
    end

    // Interrupt output gated by mask, receive interrupt enable and irq control
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq                  <= 1'b0;
            receive_irq_priority <= 1'b0;
        end else begin
            irq <= |(irqs_ff & irqm_ff) && ctrl_ff[ASR_C_RIE]
                   && intc_ff[ASR_INTC_GIE] && intc_ff[ASR_INTC_PERIPHERAL_IRQ_ENABLE]; // [R8] [R12]
            receive_irq_priority <= ctrl_ff[ASR_C_PRIO];             // [R13]
        end
    end

    // APB read path, zero-wait, unmapped reads zero with error
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prdata  <= ASR_ZERO;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            prdata  <= ASR_ZERO;
            if (psel && !penable) begin
                case (paddr)
                    ASR_CTRL_ADDR: prdata <= {23'h0, ctrl_ff};
                    ASR_DIVL_ADDR: prdata <= {24'h0, div_lo_ff};
                    ASR_DIVH_ADDR: prdata <= {24'h0, div_hi_ff};
                    ASR_STAT_ADDR: prdata <= {28'h0, full_ff, oerr_ff,
                                              hold_ff.ferr, hold_ff.ninth}; // [R9]
                    ASR_DATA_ADDR: prdata <= {24'h0, hold_ff.data};  // [R10]
                    ASR_IRQS_ADDR: prdata <= {29'h0, irqs_ff};
                    ASR_IRQM_ADDR: prdata <= {29'h0, irqm_ff};
                    ASR_INTC_ADDR: prdata <= {24'h0, intc_ff};
                    default:       pslverr <= 1'b1;
                endcase
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    sequence stop_seen_s;
        tick_ff && state_ff == ASR_STOP && ovs_ff == ASR_OVS_LAST && rx_on;
    endsequence

    property stop_done_p;
        @(posedge clk) disable iff (rst) stop_seen_s |=> done_ff;
    endproperty
    stop_done_a: assert property (stop_done_p)  // [R2]
        else $error("stop sample did not finish character");

    off_idle_a: assert property (@(posedge clk) disable iff (rst)
        !rx_on |=> state_ff == ASR_IDLE)  // [R5]
        else $error("receiver active while disabled");

    char_full_a: assert property (@(posedge clk) disable iff (rst)
        done_ff && accept && !full_ff |=> full_ff && irqs_ff[ASR_I_RX])  // [R8]
        else $error("character not delivered");

    addr_drop_a: assert property (@(posedge clk) disable iff (rst)
        done_ff && !accept && !(rd_en && paddr == ASR_DATA_ADDR)
        |=> $stable(full_ff) && $stable(hold_ff))  // [R14]
        else $error("non-address character stored");

    overrun_set_a: assert property (@(posedge clk) disable iff (rst)
        done_ff && accept && full_ff && ctrl_ff[ASR_C_CONTINUOUS_RECEIVE_ENABLE]
        |=> oerr_ff && !rx_on)  // [R16]
        else $error("overrun not flagged");

    err_clear_a: assert property (@(posedge clk) disable iff (rst)
        !ctrl_ff[ASR_C_CONTINUOUS_RECEIVE_ENABLE] |=> !oerr_ff && !hold_ff.ferr)  // [R11]
        else $error("errors kept with receive off");

    ferr_keep_a: assert property (@(posedge clk) disable iff (rst)
        done_ff && accept && !full_ff && ctrl_ff[ASR_C_CONTINUOUS_RECEIVE_ENABLE]
        |=> hold_ff.ferr == $past(done_ferr_ff))  // [R15]
        else $error("framing flag mismatch");

    irq_gate_a: assert property (@(posedge clk) disable iff (rst)
        irq |-> $past(intc_ff[ASR_INTC_GIE]) && $past(ctrl_ff[ASR_C_RIE]))  // [R12]
        else $error("irq without enables");

    tick_rate_a: assert property (@(posedge clk) disable iff (rst)
        tick_ff && $past(port_on) |-> !$past(tick_ff) || $past(div_tick) == 19'h00001)  // [R3]
        else $error("tick spacing wrong");
endmodule
`default_nettype wire

// File: testbench/asr_line_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Remote transmitter on the serial line
// ****************************************
module asr_line_model (
    // Clock
    input  wire logic clk,
    // Serial line, idle high
    output logic      line
);
    // Line rests at the idle mark level between frames
    initial line = 1'b1;

    // Start bit, nb data bits LSB first, stop bit, one idle bit
    task automatic send(input logic [8:0] v, input int nb, input logic stop_lvl,
                        input int bc);
        int i;
        for (i = -1; i <= nb + 1; i++) begin
            if (i < 0) line <= 1'b0;
            else if (i < nb) line <= v[i];
            else if (i == nb) line <= stop_lvl; // Low here forces a bad stop
            else line <= 1'b1;
            repeat (bc) @(posedge clk);
        end
    endtask
endmodule
`default_nettype wire

// File: testbench/asr_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module asr_top_tb;
    import asr_pkg::*;
    // Bench signals
    logic        clk;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        rx_line;
    logic        irq;
    logic        irq_prio;
    logic [31:0] rd;
    logic        last_err;
    logic [8:0]  v;
    logic        nine;
    logic        hs;
    logic        ws;
    logic [7:0]  dl;
    int          t_clk;
    int          errors;
    int          n_compared;
    // Divisors per speed setting; wide divider with high speed needs more than one
    logic [7:0]  dl_tab [3] = '{8'h01, 8'h00, 8'h02};

    asr_top u_asr_top (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .receive_pin(rx_line), .irq(irq),
        .receive_irq_priority(irq_prio));
    asr_line_model u_asr_line_model (.clk(clk), .line(rx_line));

    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ****************************************
    // Compare, bus and helper routines
    // ****************************************
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_pin(input logic got, input logic exp);
        chk_reg({31'h0, got}, {31'h0, exp});
    endtask
    // One APB transfer; waits for pready, no assumed latency
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        // A slave that never answers ends the run as a failure
        if (pready !== 1'b1) begin
            errors++;
            conclude();
        end
        rd = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, ASR_ZERO);
        chk_reg(rd, exp);
    endtask
    // Bounded wait for the interrupt level, then compare it
    task automatic wait_irq(input logic exp);
        int n;
        n = 0;
        while (irq !== exp && n < 40) begin
            @(posedge clk);
            n++;
        end
        chk_pin(irq, exp);
    endtask
    function automatic logic [31:0] ctl(input logic serial_port_enable, sync, continuous_receive_enable, nine, adr, prio);
        ctl = ASR_ZERO;
        ctl[ASR_C_SERIAL_PORT_ENABLE] = serial_port_enable;
        ctl[ASR_C_SYNC] = sync;
        ctl[ASR_C_CONTINUOUS_RECEIVE_ENABLE] = continuous_receive_enable;
        ctl[ASR_C_NINE] = nine;
        ctl[ASR_C_ADDR] = adr;
        ctl[ASR_C_HSEL] = hs;
        ctl[ASR_C_WSEL] = ws;
        ctl[ASR_C_RIE] = 1'b1;
        ctl[ASR_C_PRIO] = prio;
    endfunction
    function automatic logic [31:0] stat(input logic ninth, ferr, oerr, full);
        stat = ASR_ZERO;
        stat[ASR_S_NINTH] = ninth;
        stat[ASR_S_FERR] = ferr;
        stat[ASR_S_OERR] = oerr;
        stat[ASR_S_FULL] = full;
    endfunction
    // Clocks per bit: sixteen ticks, tick from divisor, quartered rate without high speed
    function automatic int bit_clocks(input logic h, w, input logic [7:0] l);
        int t;
        t = w ? int'({8'h00, l}) + 1 : int'(l) + 1;
        if (!h) t = t * 4;
        return 16 * t;
    endfunction
    // Read back a held character and acknowledge its flag
    task automatic take(input logic [8:0] val, input logic nine_on);
        rd_chk(ASR_STAT_ADDR, stat(nine_on & val[8], 1'b0, 1'b0, 1'b1));
        rd_chk(ASR_DATA_ADDR, {24'h0, val[7:0]});
        rd_chk(ASR_IRQS_ADDR, 32'h1);
        apb(1'b1, ASR_IRQS_ADDR, 32'h1);
        wait_irq(1'b0);
    endtask
    task automatic frame(input logic [8:0] val, input int nb, input logic stop_lvl);
        u_asr_line_model.send(val, nb, stop_lvl, t_clk);
    endtask
    task automatic conclude;
        if (errors == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // Watchdog at 40k cycles, well beyond the expected run of some 13k cycles
    initial begin
        #160_000;
        errors++;
        conclude();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = ASR_ZERO;
        errors = 0;
        n_compared = 0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        void'($urandom(22));
        rd_chk(ASR_CTRL_ADDR, ASR_ZERO);
        rd_chk(ASR_STAT_ADDR, ASR_ZERO);
        rd_chk(12'h0FC, ASR_ZERO);
        chk_pin(last_err, 1'b1);
        apb(1'b1, ASR_IRQM_ADDR, 32'h1);
        apb(1'b1, ASR_INTC_ADDR, 32'hC0);
        // Random characters at three rate settings, corners first
        for (int c = 0; c < 3; c++) begin
            hs = (c != 1);
            ws = (c == 2);
            dl = dl_tab[c];
            apb(1'b1, ASR_DIVL_ADDR, {24'h0, dl});
            apb(1'b1, ASR_DIVH_ADDR, ASR_ZERO);
            t_clk = bit_clocks(hs, ws, dl);
            for (int k = 0; k < 4; k++) begin
                nine = (k < 2) ? 1'b1 : 1'($urandom % 2);
                v = (k == 0) ? 9'h1FF : (k == 1) ? 9'h000 : 9'($urandom);
                apb(1'b1, ASR_CTRL_ADDR, ctl(1'b1, 1'b0, 1'b1, nine, 1'b0, 1'b0));
                frame(v, nine ? 9 : 8, 1'b1);
                wait_irq(1'b1);
                take(v, nine);
            end
        end
        // Clocked mode, port off, continuous receive off: nothing taken
        for (int d = 0; d < 3; d++) begin
            apb(1'b1, ASR_CTRL_ADDR, ctl(d != 1, d == 0, d != 2, 1'b0, 1'b0, 1'b0));
            frame(9'h0A5, 8, 1'b1);
            rd_chk(ASR_STAT_ADDR, ASR_ZERO);
        end
        // Peripheral enable off, then mask off
        apb(1'b1, ASR_INTC_ADDR, 32'h80);
        apb(1'b1, ASR_CTRL_ADDR, ctl(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0));
        frame(9'h03C, 8, 1'b1);
        rd_chk(ASR_IRQS_ADDR, 32'h1);
        chk_pin(irq, 1'b0);
        apb(1'b1, ASR_INTC_ADDR, 32'hC0);
        wait_irq(1'b1);
        apb(1'b1, ASR_IRQM_ADDR, ASR_ZERO);
        wait_irq(1'b0);
        apb(1'b1, ASR_IRQM_ADDR, 32'h1);
        take(9'h03C, 1'b0);
        // Bad stop bit, error dropped with continuous receive
        frame(9'h055, 8, 1'b0);
        rd_chk(ASR_STAT_ADDR, stat(1'b0, 1'b1, 1'b0, 1'b1));
        rd_chk(ASR_IRQS_ADDR, 32'h3);
        apb(1'b1, ASR_CTRL_ADDR, ctl(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
        apb(1'b0, ASR_STAT_ADDR, ASR_ZERO);
        chk_pin(rd[ASR_S_FERR], 1'b0);
        apb(1'b0, ASR_DATA_ADDR, ASR_ZERO);
        apb(1'b1, ASR_IRQS_ADDR, 32'h7);
        apb(1'b1, ASR_CTRL_ADDR, ctl(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0));
        // Overrun keeps the first character and halts reception
        frame(9'h011, 8, 1'b1);
        frame(9'h022, 8, 1'b1);
        rd_chk(ASR_STAT_ADDR, stat(1'b0, 1'b0, 1'b1, 1'b1));
        rd_chk(ASR_IRQS_ADDR, 32'h5);
        rd_chk(ASR_DATA_ADDR, 32'h11);
        frame(9'h033, 8, 1'b1);
        rd_chk(ASR_STAT_ADDR, stat(1'b0, 1'b0, 1'b1, 1'b0));
        apb(1'b1, ASR_CTRL_ADDR, ctl(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
        apb(1'b0, ASR_STAT_ADDR, ASR_ZERO);
        chk_pin(rd[ASR_S_OERR], 1'b0);
        apb(1'b1, ASR_IRQS_ADDR, 32'h7);
        // Address detect with high priority
        apb(1'b1, ASR_CTRL_ADDR, ctl(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1));
        repeat (2) @(posedge clk);
        chk_pin(irq_prio, 1'b1);
        frame(9'h0AA, 9, 1'b1);
        rd_chk(ASR_IRQS_ADDR, ASR_ZERO);
        frame(9'h1B7, 9, 1'b1);
        wait_irq(1'b1);
        take(9'h1B7, 1'b1);
        apb(1'b1, ASR_CTRL_ADDR, ctl(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1));
        frame(9'h044, 9, 1'b1);
        wait_irq(1'b1);
        take(9'h044, 1'b1);
        conclude();
    end
endmodule
`default_nettype wire
